// ---- common/acdm_pkg.sv ----
// constants shared by the ac disconnect monitor
package acdm_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned NUM_PORTS = 4;
   // oscillator presence window
   localparam int unsigned OSC_WIN_MS = 250;
   localparam int unsigned OSC_WIN_CYC = (CLK_HZ / 1000) * OSC_WIN_MS;
   // disconnect timer tick
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
   // disconnect durations in ticks for each select code
   localparam int unsigned TIMER_W = 10;
   localparam logic [9:0] DIS_TICKS_0 = 10'h064;
   localparam logic [9:0] DIS_TICKS_1 = 10'h0C8;
   localparam logic [9:0] DIS_TICKS_2 = 10'h12C;
   localparam logic [9:0] DIS_TICKS_3 = 10'h190;
   // register offsets
   localparam logic [4:0] OFS_FAULT = 5'h06;
   localparam logic [4:0] OFS_SUPPLY_EVT = 5'h0A;
   localparam logic [4:0] OFS_EVT_MASK = 5'h0B;
   localparam logic [4:0] OFS_SENSE_CFG = 5'h13;
   localparam logic [4:0] OFS_TIMING_CFG = 5'h16;
   localparam logic [4:0] OFS_CONTROL = 5'h1A;
   // field positions
   localparam int unsigned POS_DC_EN = 0;
   localparam int unsigned POS_AC_EN = 4;
   localparam int unsigned POS_DIS_FLT = 4;
   localparam int unsigned POS_DIS_SEL = 0;
   localparam int unsigned POS_OSC_FAIL = 1;
   localparam int unsigned POS_RESET_ALL = 7;
   // reset values
   localparam logic [7:0] RST_SENSE_CFG = 8'h0F;
   localparam logic [7:0] RST_TIMING_CFG = 8'h00;
   localparam logic [7:0] RST_FAULT = 8'h00;
   localparam logic [7:0] RST_SUPPLY_EVT = 8'h02;
   localparam logic [7:0] RST_EVT_MASK = 8'h00;
endpackage

// ---- common/acdm_osc_if.sv ----
// oscillator monitor signals between the monitor and its user
`timescale 1ns/1ps
interface acdm_osc_if;
   logic below_low;
   logic above_high;
   logic cycle_pulse;
   logic missing_pulse;
   modport mon (input below_low, input above_high, output cycle_pulse, output missing_pulse);
   modport user (output below_low, output above_high, input cycle_pulse, input missing_pulse);
endinterface

// ---- design/acdm_osc_mon.sv ----
// oscillator cycle detector and presence watchdog
`timescale 1ns/1ps
module acdm_osc_mon #(
   parameter int unsigned WIN_CYC = acdm_pkg::OSC_WIN_CYC
) (
   input wire logic clk,
   input wire logic rst,
   acdm_osc_if.mon osc
);
   localparam int unsigned CW = $clog2(WIN_CYC);

   typedef struct packed {
      logic armed;
      logic seen_low;
      logic seen_high;
      logic [CW-1:0] cnt;
      logic cyc;
      logic miss;
   } acdm_osc_state_t;

   acdm_osc_state_t s_reg;
   acdm_osc_state_t s_next;

   always_comb
   begin
      s_next = s_reg;
      s_next.cyc = 1'b0;
      s_next.miss = 1'b0;
      // one cycle per low excursion followed by a high excursion
      if (osc.below_low)
      begin
         s_next.armed = 1'b1;
         s_next.seen_low = 1'b1;
      end
      if (osc.above_high)
      begin
         s_next.seen_high = 1'b1;
         if (s_reg.armed)
         begin
            s_next.armed = 1'b0;
            s_next.cyc = 1'b1;
         end
      end
      if (s_reg.cnt == CW'(WIN_CYC - 1))
      begin
         s_next.cnt = '0;
         s_next.miss = ~(s_reg.seen_low & s_reg.seen_high);
         s_next.seen_low = osc.below_low;
         s_next.seen_high = osc.above_high;
      end
      else
      begin
         s_next.cnt = s_reg.cnt + CW'(1);
      end
      if (rst)
      begin
         s_next = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      s_reg <= s_next;
   end

   assign osc.cycle_pulse = s_reg.cyc;
   assign osc.missing_pulse = s_reg.miss;

   a_missing_at_end: assert property (@(posedge clk) disable iff (rst)
      s_reg.miss |-> $past(s_reg.cnt) == CW'(WIN_CYC - 1))
      else $error("oscillator miss reported mid window");
endmodule // acdm_osc_mon

// ---- design/acdm_top.sv ----
// per-port ac/dc disconnect timers, oscillator fault flag and interrupt
// Overview of operation
// - a powered port whose ac current stays low lets its disconnect timer count up.
// - when the timer reaches the selected duration the port is turned off and its fault bit set.
// - ac current above threshold before expiry resets the timer and keeps the port on.
// - clearing a port's ac sense enable bit disables ac-sensed disconnection there.
// - the disconnect duration comes from the two select bits of the timing register.
// - the ac path resets the timer once per oscillator cycle, only if current was high at any point during that cycle.
// - ac and dc timer resets are ored so either enabled method keeps the port powered.
// - with the oscillator gone an ac-only port disconnects through normal expiry.
// - a missing oscillator with the mask bit set sets the oscillator fault flag and interrupts.
// - the oscillator fault flag only drives the interrupt and never touches port power.
// - the oscillator counts as present only if it goes low and high in every window.
// - every reset (sys, reset pin, software reset-all) sets the oscillator fault flag.
// - once cleared the flag is set again only by a bad oscillator or another reset.
// - outside a reset the interrupt output changes only between bus transactions, stop to start; any reset forces it high at once.
// - the dc path resets the timer while undercurrent is absent, restarting from zero.
`timescale 1ns/1ps
module acdm_top #(
   parameter int unsigned OSC_WIN_CYC = acdm_pkg::OSC_WIN_CYC,
   parameter int unsigned TICK_CYC = acdm_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rst_pin_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic bus_start,
   input wire logic bus_stop,
   output logic int_n,
   input wire logic osc_below_low,
   input wire logic osc_above_high,
   input wire logic [3:0] ac_current_high,
   input wire logic [3:0] dc_undercurrent,
   input wire logic [3:0] port_power_on,
   output logic [3:0] port_off
);
   localparam int unsigned NP = acdm_pkg::NUM_PORTS;
   localparam int unsigned TW = acdm_pkg::TIMER_W;
   localparam int unsigned KW = $clog2(TICK_CYC);

   typedef struct packed {
      logic [7:0] sense_cfg;
      logic [7:0] timing_cfg;
      logic [7:0] fault;
      logic [7:0] supply_evt;
      logic [7:0] evt_mask;
      logic [KW-1:0] tick_cnt;
      logic [NP-1:0][TW-1:0] timer;
      logic [NP-1:0] ac_seen;
      logic [NP-1:0] off;
      logic bus_busy;
      logic int_n;
      logic soft_rst;
      logic [7:0] rdata;
   } acdm_state_t;

   acdm_state_t s_reg;
   acdm_state_t s_next;

   acdm_osc_if osc ();

   assign osc.below_low = osc_below_low;
   assign osc.above_high = osc_above_high;

   acdm_osc_mon #(
      .WIN_CYC(OSC_WIN_CYC)
   ) u_osc (
      .clk(clk),
      .rst(sys_rst),
      .osc(osc)
   );

   function automatic logic [TW-1:0] dis_ticks(input logic [1:0] sel);
      unique case (sel)
         2'h0: dis_ticks = acdm_pkg::DIS_TICKS_0;
         2'h1: dis_ticks = acdm_pkg::DIS_TICKS_1;
         2'h2: dis_ticks = acdm_pkg::DIS_TICKS_2;
         2'h3: dis_ticks = acdm_pkg::DIS_TICKS_3;
      endcase
   endfunction

   function automatic logic [7:0] reg_read(input acdm_state_t s, input logic [4:0] a);
      reg_read = 8'h00;
      if (a == acdm_pkg::OFS_FAULT) reg_read = s.fault;
      if (a == acdm_pkg::OFS_SUPPLY_EVT) reg_read = s.supply_evt;
      if (a == acdm_pkg::OFS_EVT_MASK) reg_read = s.evt_mask;
      if (a == acdm_pkg::OFS_SENSE_CFG) reg_read = s.sense_cfg;
      if (a == acdm_pkg::OFS_TIMING_CFG) reg_read = s.timing_cfg;
   endfunction

   logic tick;
   logic [NP-1:0] ac_en;
   logic [NP-1:0] dc_en;
   logic [NP-1:0] ac_rst;
   logic [NP-1:0] dc_rst;
   logic [NP-1:0] flt_set;
   logic [TW-1:0] dur;
   logic osc_set;
   logic int_req;
   logic wr_hit_fault;
   logic wr_hit_evt;

   assign tick = s_reg.tick_cnt == KW'(TICK_CYC - 1);
   assign ac_en = s_reg.sense_cfg[acdm_pkg::POS_AC_EN +: NP];
   assign dc_en = s_reg.sense_cfg[acdm_pkg::POS_DC_EN +: NP];
   assign dur = dis_ticks(s_reg.timing_cfg[acdm_pkg::POS_DIS_SEL +: 2]);
   // ac request only on an oscillator cycle edge, never a level
   assign ac_rst = {NP{osc.cycle_pulse}} & (s_reg.ac_seen | ac_current_high) & ac_en;
   assign dc_rst = dc_en & ~dc_undercurrent;
   assign osc_set = osc.missing_pulse & s_reg.evt_mask[acdm_pkg::POS_OSC_FAIL];
   assign int_req = |(s_reg.supply_evt & s_reg.evt_mask);
   assign wr_hit_fault = reg_wr_en && reg_addr == acdm_pkg::OFS_FAULT;
   assign wr_hit_evt = reg_wr_en && reg_addr == acdm_pkg::OFS_SUPPLY_EVT;

   always_comb
   begin
      s_next = s_reg;
      s_next.off = '0;
      s_next.soft_rst = 1'b0;
      flt_set = '0;
      s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + KW'(1);
      // per-oscillator-cycle memory of high ac current
      s_next.ac_seen = osc.cycle_pulse ? '0 : (s_reg.ac_seen | ac_current_high);
      for (int p = 0; p < NP; p++)
      begin
         if (!port_power_on[p])
         begin
            s_next.timer[p] = '0;
         end
         else if (ac_rst[p] || dc_rst[p])
         begin
            s_next.timer[p] = '0;
         end
         else if ((ac_en[p] || dc_en[p]) && tick)
         begin
            // no ac resets arrive without an oscillator, so expiry follows unless the dc path resets
            if (s_reg.timer[p] >= dur - TW'(1))
            begin
               s_next.timer[p] = '0;
               s_next.off[p] = 1'b1;
               flt_set[p] = 1'b1;
            end
            else
            begin
               s_next.timer[p] = s_reg.timer[p] + TW'(1);
            end
         end
      end
      if (reg_wr_en)
      begin
         if (reg_addr == acdm_pkg::OFS_EVT_MASK) s_next.evt_mask = reg_wdata;
         if (reg_addr == acdm_pkg::OFS_SENSE_CFG) s_next.sense_cfg = reg_wdata;
         if (reg_addr == acdm_pkg::OFS_TIMING_CFG) s_next.timing_cfg = reg_wdata;
         if (reg_addr == acdm_pkg::OFS_CONTROL)
         begin
            s_next.soft_rst = reg_wdata[acdm_pkg::POS_RESET_ALL];
         end
      end
      // write one to clear; a new event in the same cycle wins
      s_next.fault = (s_reg.fault & ~(wr_hit_fault ? reg_wdata : 8'h00))
         | {flt_set, 4'h0};
      s_next.supply_evt = s_reg.supply_evt & ~(wr_hit_evt ? reg_wdata : 8'h00);
      s_next.supply_evt[acdm_pkg::POS_OSC_FAIL] =
         s_next.supply_evt[acdm_pkg::POS_OSC_FAIL] | osc_set;
      if (reg_rd_en)
      begin
         s_next.rdata = reg_read(s_reg, reg_addr);
      end
      // a start seen in this cycle already blocks the update
      if (bus_start)
      begin
         s_next.bus_busy = 1'b1;
      end
      else if (bus_stop)
      begin
         s_next.bus_busy = 1'b0;
      end
      if (!bus_start && !s_reg.bus_busy)
      begin
         s_next.int_n = ~int_req;
      end
      if (sys_rst || !rst_pin_n || s_reg.soft_rst)
      begin
         s_next = '0;
         s_next.sense_cfg = acdm_pkg::RST_SENSE_CFG;
         s_next.timing_cfg = acdm_pkg::RST_TIMING_CFG;
         s_next.fault = acdm_pkg::RST_FAULT;
         s_next.supply_evt = acdm_pkg::RST_SUPPLY_EVT;
         s_next.evt_mask = acdm_pkg::RST_EVT_MASK;
         s_next.int_n = 1'b1;
         // bus state survives a soft reset so a transaction in flight still blocks
         s_next.bus_busy = sys_rst ? 1'b0 : s_reg.bus_busy;
      end
   end

   always_ff @(posedge clk)
   begin
      s_reg <= s_next;
   end

   assign reg_rdata = s_reg.rdata;
   assign int_n = s_reg.int_n;
   assign port_off = s_reg.off;

   // assertion helpers
   logic any_rst;
   assign any_rst = sys_rst || !rst_pin_n || s_reg.soft_rst;

   a_int_only_idle: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(int_n) |-> !$past(s_reg.bus_busy) && !$past(bus_start)
      || $past(any_rst))
      else $error("interrupt changed during a transaction");

   a_expiry_count: assert property (@(posedge clk) disable iff (any_rst)
      port_off[0] |-> $past(s_reg.timer[0]) >= $past(dur) - TW'(1)
      && $past(tick))
      else $error("port 0 turned off before timer expiry");

   a_fault_on_off: assert property (@(posedge clk) disable iff (any_rst)
      port_off[1] |=> s_reg.fault[acdm_pkg::POS_DIS_FLT + 1])
      else $error("port 1 turned off without fault bit");

   a_unpowered_zero: assert property (@(posedge clk) disable iff (any_rst)
      !port_power_on[2] |=> s_reg.timer[2] == '0 && !port_off[2])
      else $error("unpowered port 2 timer running");

   a_ac_disabled: assert property (@(posedge clk) disable iff (any_rst)
      osc.cycle_pulse && !ac_en[3] && !dc_rst[3] && port_power_on[3] && !tick
      && s_reg.timer[3] != '0 |=> s_reg.timer[3] == $past(s_reg.timer[3]))
      else $error("disabled ac sense reset port 3 timer");

   a_ac_reset_cycle: assert property (@(posedge clk) disable iff (any_rst)
      osc.cycle_pulse && ac_en[0] && ac_current_high[0] && port_power_on[0]
      |=> s_reg.timer[0] == '0 && !port_off[0])
      else $error("ac reset did not clear port 0 timer");

   a_ac_no_level: assert property (@(posedge clk) disable iff (any_rst)
      !osc.cycle_pulse && !dc_en[0] && port_power_on[0] && tick
      && s_reg.timer[0] < dur - TW'(1) && ac_en[0]
      |=> s_reg.timer[0] == $past(s_reg.timer[0]) + TW'(1))
      else $error("ac path reset timer outside a cycle edge");

   a_dc_or_keeps: assert property (@(posedge clk) disable iff (any_rst)
      dc_en[1] && !dc_undercurrent[1] && port_power_on[1]
      |=> s_reg.timer[1] == '0 && !port_off[1])
      else $error("dc path did not hold port 1 timer");

   a_osc_flag_set: assert property (@(posedge clk) disable iff (any_rst)
      osc.missing_pulse && s_reg.evt_mask[acdm_pkg::POS_OSC_FAIL]
      |=> s_reg.supply_evt[acdm_pkg::POS_OSC_FAIL])
      else $error("missing oscillator did not set flag");

   a_osc_flag_cause: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(s_reg.supply_evt[acdm_pkg::POS_OSC_FAIL])
      |-> $past(osc_set) || $past(any_rst))
      else $error("oscillator flag set without cause");

   a_reset_sets_flag: assert property (@(posedge clk)
      any_rst |=> s_reg.supply_evt[acdm_pkg::POS_OSC_FAIL] && int_n)
      else $error("reset left oscillator flag clear");

   a_flag_no_power: assert property (@(posedge clk) disable iff (any_rst)
      port_off != '0 |-> $past(flt_set) == port_off)
      else $error("port turned off without timer expiry");

   c_port_expiry: cover property (@(posedge clk) disable iff (any_rst) port_off[0]);
   c_osc_fault: cover property (@(posedge clk) disable iff (any_rst) osc_set);
   c_int_deferred: cover property (@(posedge clk) disable iff (any_rst)
      s_reg.bus_busy && int_req && int_n ##1 !s_reg.bus_busy ##1 !int_n);
   c_ac_keep: cover property (@(posedge clk) disable iff (any_rst) ac_rst[1]);
endmodule // acdm_top

// ---- sim/acdm_far_end.sv ----
// oscillator source and powered port loads seen by the monitor
`timescale 1ns/1ps
module acdm_far_end (
   input wire logic clk,
   input wire logic osc_run,
   input wire logic [9:0] osc_half,
   input wire logic [3:0] ac_load,
   input wire logic [3:0] dc_load,
   input wire logic [3:0] power_cmd,
   input wire logic [3:0] port_off,
   output logic osc_below_low,
   output logic osc_above_high,
   output logic [3:0] ac_current_high,
   output logic [3:0] dc_undercurrent,
   output logic [3:0] port_power_on
);
   logic [9:0] cnt_reg = 10'h000;
   logic phase_reg = 1'b0;
   logic [3:0] tripped_reg = 4'h0;
   always @(posedge clk)
   begin
      if (osc_run)
      begin
         if (cnt_reg >= osc_half - 10'h001)
         begin
            cnt_reg <= 10'h000;
            phase_reg <= ~phase_reg;
         end
         else
            cnt_reg <= cnt_reg + 10'h001;
      end
      // a tripped port stays dark until the host drops its command
      tripped_reg <= (tripped_reg | port_off) & power_cmd;
   end
   // a stopped oscillator parks mid-rail and crosses neither level
   assign osc_below_low = osc_run & ~phase_reg;
   assign osc_above_high = osc_run & phase_reg;
   assign port_power_on = power_cmd & ~tripped_reg;
   // no ac current flows without the oscillator driving the port
   assign ac_current_high = ac_load & port_power_on & {4{osc_run}};
   assign dc_undercurrent = port_power_on & ~dc_load;
endmodule // acdm_far_end

// ---- sim/acdm_testbench.sv ----
// self-checking bench for the ac disconnect monitor
`timescale 1ns/1ps
module testbench;
   localparam int T = 4;
   localparam int LIMIT = 40000;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rst_pin_n = 1'b1;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic bus_start = 1'b0;
   logic bus_stop = 1'b0;
   logic int_n;
   logic osc_run = 1'b1;
   logic [9:0] osc_half = 10'h00A;
   logic [3:0] ac_load = 4'h0;
   logic [3:0] dc_load = 4'h0;
   logic [3:0] power_cmd = 4'h0;
   logic osc_below_low;
   logic osc_above_high;
   logic [3:0] ac_current_high;
   logic [3:0] dc_undercurrent;
   logic [3:0] port_power_on;
   logic [3:0] port_off;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   always #4 clk = ~clk;
   acdm_top #(.OSC_WIN_CYC(200), .TICK_CYC(T)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_start(bus_start),
      .bus_stop(bus_stop), .int_n(int_n), .osc_below_low(osc_below_low),
      .osc_above_high(osc_above_high), .ac_current_high(ac_current_high),
      .dc_undercurrent(dc_undercurrent), .port_power_on(port_power_on),
      .port_off(port_off));
   acdm_far_end far_u (
      .clk(clk), .osc_run(osc_run), .osc_half(osc_half), .ac_load(ac_load),
      .dc_load(dc_load), .power_cmd(power_cmd), .port_off(port_off),
      .osc_below_low(osc_below_low), .osc_above_high(osc_above_high),
      .ac_current_high(ac_current_high), .dc_undercurrent(dc_undercurrent),
      .port_power_on(port_power_on));
   task automatic end_sim();
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr_en <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      @(negedge clk);
      check(nm, reg_rdata, exp);
   endtask
   // counts cycles until the port is dropped; the tick phase blurs the edge
   task automatic wait_off(input int p, input int lo, input int hi);
      int n;
      n = 0;
      while (port_off[p] !== 1'b1 && n <= hi)
      begin
         @(negedge clk);
         n = n + 1;
      end
      check("expiry_time", 8'(n >= lo && n <= hi), 8'h01);
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         n_errors = n_errors + 1;
         end_sim();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rd("sense_cfg", 5'h13, 8'h0F);
      rd("timing_cfg", 5'h16, 8'h00);
      rd("fault", 5'h06, 8'h00);
      rd("supply_evt", 5'h0A, 8'h02);
      rd("unmapped", 5'h1F, 8'h00);
      check("int_idle", {7'h00, int_n}, 8'h01);
      wr(5'h0B, 8'h02);
      repeat (3) @(negedge clk);
      check("int_masked", {7'h00, int_n}, 8'h00);
      wr(5'h0A, 8'h02);
      repeat (600) @(negedge clk);
      rd("osc_ok", 5'h0A, 8'h00);
      check("int_clear", {7'h00, int_n}, 8'h01);
      @(posedge clk);
      bus_start <= 1'b1;
      osc_run <= 1'b0;
      @(posedge clk);
      bus_start <= 1'b0;
      repeat (500) @(negedge clk);
      rd("osc_fail", 5'h0A, 8'h02);
      check("int_frozen", {7'h00, int_n}, 8'h01);
      @(posedge clk);
      bus_stop <= 1'b1;
      @(posedge clk);
      bus_stop <= 1'b0;
      repeat (3) @(negedge clk);
      check("int_after_stop", {7'h00, int_n}, 8'h00);
      // oscillator still gone: ac-only port falls, dc-only port stays
      wr(5'h13, 8'h12);
      ac_load <= 4'h1;
      dc_load <= 4'h2;
      power_cmd <= 4'h3;
      wait_off(0, 98 * T, 101 * T + 4);
      repeat (400) @(negedge clk);
      check("dc_port_on", {4'h0, port_power_on}, 8'h02);
      @(posedge clk);
      power_cmd <= 4'h0;
      osc_run <= 1'b1;
      ac_load <= 4'h0;
      wr(5'h06, 8'hF0);
      wr(5'h13, 8'h10);
      for (int s = 0; s < 4; s++)
      begin
         wr(5'h16, 8'(s));
         power_cmd <= 4'h1;
         wait_off(0, (100 * (s + 1) - 2) * T, (100 * (s + 1) + 1) * T + 4);
         rd("fault_bit", 5'h06, 8'h10);
         wr(5'h06, 8'h10);
         power_cmd <= 4'h0;
      end
      wr(5'h16, 8'h00);
      // port 1 kept by ac alone, port 3 falls with ac current but ac sense off
      wr(5'h13, 8'h3E);
      ac_load <= 4'hB;
      dc_load <= 4'h0;
      power_cmd <= 4'hF;
      wait_off(2, 98 * T, 101 * T + 4);
      repeat (800) @(negedge clk);
      check("ports_held", {4'h0, port_power_on}, 8'h03);
      rd("fault_one", 5'h06, 8'hC0);
      @(posedge clk);
      power_cmd <= 4'h0;
      wr(5'h06, 8'hF0);
      wr(5'h13, 8'h02);
      dc_load <= 4'h0;
      power_cmd <= 4'h2;
      repeat (200) @(posedge clk);
      dc_load <= 4'h2;
      repeat (8) @(posedge clk);
      dc_load <= 4'h0;
      wait_off(1, 98 * T, 101 * T + 4);
      @(posedge clk);
      power_cmd <= 4'h0;
      // one ac reset per slow oscillator cycle cannot outrun the timer
      wr(5'h0A, 8'h02);
      osc_half <= 10'h12C;
      wr(5'h13, 8'h10);
      ac_load <= 4'h1;
      power_cmd <= 4'h1;
      wait_off(0, 98 * T, 1010);
      // a 600-cycle oscillator period leaves some 200-cycle windows one-sided
      repeat (300) @(negedge clk);
      rd("slow_osc", 5'h0A, 8'h02);
      @(posedge clk);
      power_cmd <= 4'h0;
      osc_half <= 10'h00A;
      repeat (500) @(posedge clk);
      wr(5'h0A, 8'h02);
      wr(5'h13, 8'h00);
      rd("flag_cleared", 5'h0A, 8'h00);
      @(posedge clk);
      rst_pin_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_pin_n <= 1'b1;
      rd("pin_reset", 5'h0A, 8'h02);
      rd("pin_cfg", 5'h13, 8'h0F);
      wr(5'h0A, 8'h02);
      wr(5'h1A, 8'h80);
      repeat (2) @(posedge clk);
      rd("soft_reset", 5'h0A, 8'h02);
      rd("ctrl_wo", 5'h1A, 8'h00);
      end_sim();
   end
endmodule // testbench
